// *** core/asr_pkg.sv ***
// Purpose: Constants shared by the asynchronous serial receiver
// Assumes: 8-bit register port, register indices are byte addresses
// Notes: Bit positions follow the control register layouts
package asr_pkg;
  // ==========================================================
  // Register indices
  localparam logic [3:0] REG_BAUD_CONTROL = 4'h0;
  localparam logic [3:0] REG_IRQ_CONTROL = 4'h1;
  localparam logic [3:0] REG_PERIPHERAL_IRQ_ENABLES = 4'h2;
  localparam logic [3:0] REG_PERIPHERAL_IRQ_FLAGS = 4'h3;
  localparam logic [3:0] REG_RECEIVE_STATUS_CONTROL = 4'h4;
  localparam logic [3:0] REG_BAUD_DIVISOR_LOW = 4'h5;
  localparam logic [3:0] REG_BAUD_DIVISOR_HIGH = 4'h6;
  localparam logic [3:0] REG_TRANSMIT_STATUS_CONTROL = 4'h7;
  localparam logic [3:0] REG_RECEIVE_DATA_PORT = 4'h8;
  localparam logic [3:0] REG_EVENT_STATUS = 4'h9;
  localparam logic [3:0] REG_EVENT_MASK = 4'hA;
  // ==========================================================
  // Field positions
  localparam int BIT_RX_IDLE = 6;
  localparam int BIT_WIDE_BAUD_DIVIDER = 3;
  localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int BIT_RX_IRQ_ENABLE = 5;
  localparam int BIT_RX_PENDING_FLAG = 5;
  localparam int BIT_SERIAL_PORT_ENABLE = 7;
  localparam int BIT_NINTH_BIT_RX_ENABLE = 6;
  localparam int BIT_CONTINUOUS_RX_ENABLE = 4;
  localparam int BIT_FRAMING_ERROR_FLAG = 2;
  localparam int BIT_OVERRUN_ERROR_FLAG = 1;
  localparam int BIT_RX_NINTH_DATA = 0;
  localparam int BIT_CLOCKED_MODE = 4;
  localparam int BIT_HIGH_SPEED_BAUD = 2;
  localparam int EVT_CHAR = 0;
  localparam int EVT_FRAME = 1;
  localparam int EVT_OVERRUN = 2;
  // Writable masks of mixed registers
  localparam logic [7:0] WMASK_BAUD_CONTROL = 8'h08;
  localparam logic [7:0] WMASK_IRQ_CONTROL = 8'hC0;
  localparam logic [7:0] WMASK_PIE = 8'h20;
  localparam logic [7:0] WMASK_RECEIVE_STATUS_CONTROL = 8'hD0;
  localparam logic [7:0] WMASK_TRANSMIT_STATUS_CONTROL = 8'h14;
  localparam logic [7:0] WMASK_EVENT = 8'h07;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ==========================================================
  // Timing
  localparam logic [3:0] TICKS_PER_BIT_M1 = 4'hF;
  localparam logic [3:0] VOTE_TICK_A = 4'h7;
  localparam logic [3:0] VOTE_TICK_B = 4'h8;
  localparam logic [3:0] VOTE_TICK_C = 4'h9;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  typedef enum logic [3:0] {
    ASR_IDLE  = 4'b0001,
    ASR_START = 4'b0010,
    ASR_DATA  = 4'b0100,
    ASR_STOP  = 4'b1000
  } asr_state_t;
endpackage

// *** core/asr_receiver.sv ***
// Function
// - Receive only with rx enable, async, port enabled
// - Sample at sixteen ticks per bit
// - Start on falling edge of idle line
// - Half-bit recheck low, else silently abandon
// - Full bit to centres, majority vote, shift
// - Eight or nine data bits per character
// - Stop bit zero sets framing error
// - After stop, push character, raise pending
// - FIFO holds two characters plus one shifting
// - Data port read pops oldest character
// - Overrun blocks reception until cleared
// - Pending while enabled and FIFO not empty
// - Pending flag cannot be written
// - Receive interrupt needs all three enables plus pending
// - Pending independent of interrupt enables
// - Shift register and FIFO not addressable
//
// Purpose: Asynchronous serial receive path with baud generator and registers
// Assumes: Serial input already synchronous to i_ref_clk
// Notes: Overrun clears when continuous receive is disabled
`timescale 1ns/1ps
module asr_receiver
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Serial line
  input wire logic i_serial_in_pin,
  // Interrupts
  output logic o_rx_irq,
  output logic o_irq
);
  // ==========================================================
  // Registers
  logic [7:0] baud_control_q, irq_control_q, pie_q, receive_status_control_q, transmit_status_control_q;
  logic [7:0] div_lo_q, div_hi_q, evt_status_q, evt_mask_q, rdata_q;
  logic [7:0] evt_status_d;
  logic [8:0] shift_q;
  logic [9:0] fifo_q [2];
  logic [1:0] cnt_q;
  logic rd_ptr_q, wr_ptr_q, overrun_error_flag_q, line_q;
  logic [17:0] tick_cnt_q;
  logic [3:0] smp_q, bits_q;
  logic [1:0] vote_q;
  asr_state_t state_q, state_d;

  wire wr_baud = i_wr && i_addr == REG_BAUD_CONTROL;
  wire wr_irqc = i_wr && i_addr == REG_IRQ_CONTROL;
  wire wr_pie = i_wr && i_addr == REG_PERIPHERAL_IRQ_ENABLES;
  wire wr_receive_status_control = i_wr && i_addr == REG_RECEIVE_STATUS_CONTROL;
  wire wr_lo = i_wr && i_addr == REG_BAUD_DIVISOR_LOW;
  wire wr_hi = i_wr && i_addr == REG_BAUD_DIVISOR_HIGH;
  wire wr_transmit_status_control = i_wr && i_addr == REG_TRANSMIT_STATUS_CONTROL;
  wire wr_mask = i_wr && i_addr == REG_EVENT_MASK;
  wire rd_data = i_rd && i_addr == REG_RECEIVE_DATA_PORT;
  wire rd_evt = i_rd && i_addr == REG_EVENT_STATUS;

  // ==========================================================
  // Enables and baud generator
  wire rx_en = receive_status_control_q[BIT_CONTINUOUS_RX_ENABLE] && !transmit_status_control_q[BIT_CLOCKED_MODE]
               && receive_status_control_q[BIT_SERIAL_PORT_ENABLE];
  wire high_speed_baud = transmit_status_control_q[BIT_HIGH_SPEED_BAUD];
  wire wide_baud_divider = baud_control_q[BIT_WIDE_BAUD_DIVIDER];
  wire [15:0] divisor = wide_baud_divider ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};
  // Divide by 64, 16 or 4 per bit; the fastest mode cannot beat one tick per clock
  wire [17:0] tick_top = (!high_speed_baud && !wide_baud_divider) ? ({2'b00, divisor} << 2) + 18'h0_0003 :
                         (high_speed_baud && wide_baud_divider) ? {4'h0, divisor[15:2]} :
                         {2'b00, divisor};
  wire tick = tick_cnt_q >= tick_top;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !rx_en || tick) begin
      tick_cnt_q <= 18'h0_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 18'h0_0001;
    end
  end

  // ==========================================================
  // Data recovery
  wire fall = line_q && !i_serial_in_pin;
  wire vote_now = tick && smp_q == VOTE_TICK_C;
  wire bit_val = (vote_q[1] & vote_q[0]) | (vote_q[1] & i_serial_in_pin)
                 | (vote_q[0] & i_serial_in_pin);
  wire [3:0] n_bits = receive_status_control_q[BIT_NINTH_BIT_RX_ENABLE] ? DATA_BITS_9 : DATA_BITS_8;
  wire stop_done = state_q == ASR_STOP && vote_now;
  wire fifo_full = cnt_q == FIFO_DEPTH;
  wire push = stop_done && !fifo_full;
  wire overrun = stop_done && fifo_full;
  wire pop = rd_data && cnt_q != 2'h0;
  wire [8:0] word = receive_status_control_q[BIT_NINTH_BIT_RX_ENABLE] ? shift_q : {1'b0, shift_q[8:1]};

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ASR_IDLE: begin
        if (fall && !overrun_error_flag_q) begin
          state_d = ASR_START;
        end
      end
      ASR_START: begin
        if (vote_now) begin
          state_d = bit_val ? ASR_IDLE : ASR_DATA;
        end
      end
      ASR_DATA: begin
        if (vote_now && bits_q == n_bits - 4'h1) begin
          state_d = ASR_STOP;
        end
      end
      ASR_STOP: begin
        if (vote_now) begin
          state_d = ASR_IDLE;
        end
      end
    endcase
    if (!rx_en) begin
      state_d = ASR_IDLE;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state_q <= ASR_IDLE;
      line_q <= 1'b1;
      smp_q <= 4'h0;
      bits_q <= 4'h0;
      vote_q <= 2'b11;
      shift_q <= 9'h000;
    end else begin
      state_q <= state_d;
      line_q <= i_serial_in_pin;
      if (state_q == ASR_IDLE) begin
        smp_q <= 4'h0;
        bits_q <= 4'h0;
      end else if (tick) begin
        smp_q <= smp_q + 4'h1;
      end
      if (tick && smp_q == VOTE_TICK_A) begin
        vote_q[1] <= i_serial_in_pin;
      end
      if (tick && smp_q == VOTE_TICK_B) begin
        vote_q[0] <= i_serial_in_pin;
      end
      if (state_q == ASR_DATA && vote_now) begin
        shift_q <= {bit_val, shift_q[8:1]};
        bits_q <= bits_q + 4'h1;
      end
    end
  end

  // ==========================================================
  // Receive FIFO, internal only
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      cnt_q <= 2'h0;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
      fifo_q[0] <= 10'h000;
      fifo_q[1] <= 10'h000;
    end else begin
      if (push) begin
        fifo_q[wr_ptr_q] <= {~bit_val, word};
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      if (!receive_status_control_q[BIT_CONTINUOUS_RX_ENABLE]) begin
        overrun_error_flag_q <= 1'b0;
      end else if (overrun) begin
        overrun_error_flag_q <= 1'b1;
      end
    end
  end

  wire [9:0] head = fifo_q[rd_ptr_q];
  wire rx_pending = rx_en && cnt_q != 2'h0;
  wire [7:0] receive_status_control_rd = (receive_status_control_q & WMASK_RECEIVE_STATUS_CONTROL)
                        | ({7'h00, head[9] && cnt_q != 2'h0} << BIT_FRAMING_ERROR_FLAG)
                        | ({7'h00, overrun_error_flag_q} << BIT_OVERRUN_ERROR_FLAG)
                        | {7'h00, head[8]};
  wire [7:0] pir_rd = {7'h00, rx_pending} << BIT_RX_PENDING_FLAG;
  wire [7:0] baud_rd = (baud_control_q & WMASK_BAUD_CONTROL)
                       | ({7'h00, state_q == ASR_IDLE} << BIT_RX_IDLE);
  wire [7:0] evt_set = {5'h00, overrun, push && !bit_val, push};

  // ==========================================================
  // Register file; shift register and FIFO storage have no address
  wire [7:0] rd_mux = (i_addr == REG_BAUD_CONTROL) ? baud_rd :
                      (i_addr == REG_IRQ_CONTROL) ? irq_control_q :
                      (i_addr == REG_PERIPHERAL_IRQ_ENABLES) ? pie_q :
                      (i_addr == REG_PERIPHERAL_IRQ_FLAGS) ? pir_rd :
                      (i_addr == REG_RECEIVE_STATUS_CONTROL) ? receive_status_control_rd :
                      (i_addr == REG_BAUD_DIVISOR_LOW) ? div_lo_q :
                      (i_addr == REG_BAUD_DIVISOR_HIGH) ? div_hi_q :
                      (i_addr == REG_TRANSMIT_STATUS_CONTROL) ? transmit_status_control_q :
                      (i_addr == REG_RECEIVE_DATA_PORT) ? head[7:0] :
                      (i_addr == REG_EVENT_STATUS) ? evt_status_q :
                      (i_addr == REG_EVENT_MASK) ? evt_mask_q : 8'h00;

  // Set wins over the clear done by reading the status
  assign evt_status_d = (rd_evt ? 8'h00 : evt_status_q) | evt_set;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      baud_control_q <= REG_RESET;
      irq_control_q <= REG_RESET;
      pie_q <= REG_RESET;
      receive_status_control_q <= REG_RESET;
      transmit_status_control_q <= REG_RESET;
      div_lo_q <= REG_RESET;
      div_hi_q <= REG_RESET;
      evt_mask_q <= REG_RESET;
      evt_status_q <= REG_RESET;
      rdata_q <= REG_RESET;
    end else begin
      if (wr_baud) baud_control_q <= i_wdata & WMASK_BAUD_CONTROL;
      if (wr_irqc) irq_control_q <= i_wdata & WMASK_IRQ_CONTROL;
      if (wr_pie) pie_q <= i_wdata & WMASK_PIE;
      if (wr_receive_status_control) receive_status_control_q <= i_wdata & WMASK_RECEIVE_STATUS_CONTROL;
      if (wr_transmit_status_control) transmit_status_control_q <= i_wdata & WMASK_TRANSMIT_STATUS_CONTROL;
      if (wr_lo) div_lo_q <= i_wdata;
      if (wr_hi) div_hi_q <= i_wdata;
      if (wr_mask) evt_mask_q <= i_wdata & WMASK_EVENT;
      evt_status_q <= evt_status_d;
      rdata_q <= i_rd ? rd_mux : 8'h00;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rx_irq = pie_q[BIT_RX_IRQ_ENABLE] && irq_control_q[BIT_PERIPHERAL_IRQ_ENABLE]
                    && irq_control_q[BIT_GLOBAL_IRQ_ENABLE] && rx_pending;
  assign o_irq = |(evt_status_q & evt_mask_q);

  // ==========================================================
  // Checks
  property p_enable;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !rx_en |=> state_q == ASR_IDLE;
  endproperty
  a_enable: assert property (p_enable) else $error("receiver active while disabled");

  property p_tick_only;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (state_q != ASR_IDLE && !tick && state_d != ASR_IDLE) |=> $stable(smp_q);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("sample count moved without tick");

  property p_abort;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (state_q == ASR_START && vote_now && bit_val) |=> state_q == ASR_IDLE
      && cnt_q <= $past(cnt_q) && !$rose(evt_status_q[EVT_FRAME]);
  endproperty
  a_abort: assert property (p_abort) else $error("false start not abandoned cleanly");

  property p_push;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (stop_done && !fifo_full && !pop && rx_en) |=> cnt_q == $past(cnt_q) + 2'h1 && rx_pending;
  endproperty
  a_push: assert property (p_push) else $error("character not stored after stop bit");

  property p_frame;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (push && !bit_val) |=> evt_status_q[EVT_FRAME];
  endproperty
  a_frame: assert property (p_frame) else $error("framing error not flagged");

  property p_depth;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    cnt_q <= FIFO_DEPTH;
  endproperty
  a_depth: assert property (p_depth) else $error("fifo count above two");

  property p_pop;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (pop && !push) |=> cnt_q == $past(cnt_q) - 2'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("data read did not remove character");

  property p_overrun;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (overrun_error_flag_q && state_q == ASR_IDLE) |=> state_q == ASR_IDLE;
  endproperty
  a_overrun: assert property (p_overrun) else $error("reception resumed during overrun");

  property p_irq;
    @(posedge i_ref_clk) disable iff (!i_rstn)
    o_rx_irq |-> rx_pending && irq_control_q[BIT_GLOBAL_IRQ_ENABLE] && pie_q[BIT_RX_IRQ_ENABLE]
      && irq_control_q[BIT_PERIPHERAL_IRQ_ENABLE];
  endproperty
  a_irq: assert property (p_irq) else $error("receive interrupt without all enables");
endmodule

// *** dv/asr_line_model.sv ***
// Purpose: Remote serial transmitter that drives the receive line
// Assumes: One bit cell lasts bit_clks reference clock cycles, BIT_CLKS until the bench retunes it
// Notes: Line idles high like a pulled-up mark; it only moves on clock edges
`timescale 1ns/1ps
module asr_line_model #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input wire logic i_ref_clk,
  // Serial line
  output logic o_line
);
  // ==========================================================
  // Frame driver
  // Bench retunes the cell length to follow a new divisor setting
  int bit_clks = BIT_CLKS;

  initial o_line = 1'b1;

  task automatic put(input logic v);
    o_line <= v;
    repeat (bit_clks) @(posedge i_ref_clk);
  endtask

  // LSB first, then stop level, then one idle cell so the push can land
  task automatic send(input logic [8:0] d, input int nbits, input logic stop);
    @(posedge i_ref_clk);
    put(1'b0);
    for (int i = 0; i < nbits; i++) begin
      put(d[i]);
    end
    put(stop);
    put(1'b1);
  endtask

  // Low pulse that is gone well before the start-bit centre
  task automatic glitch(input int clks);
    @(posedge i_ref_clk);
    o_line <= 1'b0;
    repeat (clks) @(posedge i_ref_clk);
    put(1'b1);
  endtask
endmodule

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the asynchronous serial receiver
// Assumes: Wide divider set, divisor 0, so one tick per clock, 16 clocks a bit
// Notes: Line driven by a transmitter model; registers through the plain port
`timescale 1ns/1ps
module tb_top
  import asr_pkg::*;
;
  logic clk, rstn, reg_wr, reg_rd, line, rx_irq, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  // ==========================================================
  // Clock, models and timeout
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  asr_receiver dut (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(reg_wr), .i_rd(reg_rd), .o_rdata(rdata), .i_serial_in_pin(line),
    .o_rx_irq(rx_irq), .o_irq(irq));
  asr_line_model #(.BIT_CLKS(16)) tx (.i_ref_clk(clk), .o_line(line));

  // Whole run is about 3500 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(rdata, exp, what);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rchk(REG_RECEIVE_STATUS_CONTROL, 8'h00, "receive_status_control reset");
    rchk(REG_PERIPHERAL_IRQ_FLAGS, 8'h00, "flags reset");
    rchk(4'hB, 8'h00, "unmapped read");
    chk(rx_irq, 1'b0, "rx irq reset");
    chk(irq, 1'b0, "irq reset");
    bus_wr(REG_BAUD_CONTROL, 8'h08);
    rchk(REG_BAUD_CONTROL, 8'h48, "idle and wide divider");
    bus_wr(REG_RECEIVE_STATUS_CONTROL, 8'h90);
    rchk(REG_RECEIVE_STATUS_CONTROL, 8'h90, "receive_status_control config");
    $display("test reset done");
  endtask

  task automatic t_basic();
    tx.send(9'h0A5, 8, 1'b1);
    rchk(REG_PERIPHERAL_IRQ_FLAGS, 8'h20, "pending set");
    rchk(REG_RECEIVE_DATA_PORT, 8'hA5, "char");
    rchk(REG_PERIPHERAL_IRQ_FLAGS, 8'h00, "pending clear");
    tx.send(9'h03C, 8, 1'b0);
    rchk(REG_RECEIVE_STATUS_CONTROL, 8'h94, "framing set");
    rchk(REG_RECEIVE_DATA_PORT, 8'h3C, "framed char");
    rchk(REG_RECEIVE_STATUS_CONTROL, 8'h90, "framing gone");
    $display("test basic done");
  endtask

  task automatic t_irq();
    logic [7:0] v;
    rchk(REG_EVENT_STATUS, 8'h03, "events");
    bus_wr(REG_EVENT_MASK, 8'h01);
    tx.send(9'h05A, 8, 1'b1);
    chk(irq, 1'b1, "event irq");
    chk(rx_irq, 1'b0, "no enables");
    rchk(REG_PERIPHERAL_IRQ_FLAGS, 8'h20, "pending no enables");
    bus_wr(REG_PERIPHERAL_IRQ_ENABLES, 8'h20);
    chk(rx_irq, 1'b0, "rx enable only");
    bus_wr(REG_IRQ_CONTROL, 8'hC0);
    chk(rx_irq, 1'b1, "all enables");
    bus_wr(REG_IRQ_CONTROL, 8'h80);
    chk(rx_irq, 1'b0, "no peripheral");
    bus_wr(REG_PERIPHERAL_IRQ_FLAGS, 8'h00);
    rchk(REG_PERIPHERAL_IRQ_FLAGS, 8'h20, "pending kept");
    rchk(REG_EVENT_STATUS, 8'h01, "char event");
    chk(irq, 1'b0, "event cleared");
    rchk(REG_RECEIVE_DATA_PORT, 8'h5A, "irq char");
    bus_wr(REG_PERIPHERAL_IRQ_FLAGS, 8'h20);
    rchk(REG_PERIPHERAL_IRQ_FLAGS, 8'h00, "pending not set");
    $display("test irq done");
  endtask

  task automatic t_overrun();
    tx.send(9'h011, 8, 1'b1);
    tx.send(9'h022, 8, 1'b1);
    tx.send(9'h033, 8, 1'b1);
    rchk(REG_RECEIVE_STATUS_CONTROL, 8'h92, "overrun");
    rchk(REG_RECEIVE_DATA_PORT, 8'h11, "oldest");
    rchk(REG_RECEIVE_DATA_PORT, 8'h22, "second");
    rchk(REG_PERIPHERAL_IRQ_FLAGS, 8'h00, "drained");
    tx.send(9'h044, 8, 1'b1);
    rchk(REG_PERIPHERAL_IRQ_FLAGS, 8'h00, "blocked");
    bus_wr(REG_RECEIVE_STATUS_CONTROL, 8'h80);
    bus_wr(REG_RECEIVE_STATUS_CONTROL, 8'h90);
    rchk(REG_RECEIVE_STATUS_CONTROL, 8'h90, "overrun cleared");
    tx.send(9'h055, 8, 1'b1);
    rchk(REG_RECEIVE_DATA_PORT, 8'h55, "after clear");
    $display("test overrun done");
  endtask

  task automatic t_modes();
    bus_wr(REG_RECEIVE_STATUS_CONTROL, 8'hD0);
    tx.send(9'h15A, 9, 1'b1);
    rchk(REG_RECEIVE_STATUS_CONTROL, 8'hD1, "ninth bit");
    rchk(REG_RECEIVE_DATA_PORT, 8'h5A, "nine bit char");
    bus_wr(REG_RECEIVE_STATUS_CONTROL, 8'h90);
    tx.glitch(4);
    rchk(REG_PERIPHERAL_IRQ_FLAGS, 8'h00, "false start");
    rchk(REG_RECEIVE_STATUS_CONTROL, 8'h90, "no error");
    tx.send(9'h066, 8, 1'b1);
    rchk(REG_RECEIVE_DATA_PORT, 8'h66, "search resumed");
    bus_wr(REG_TRANSMIT_STATUS_CONTROL, 8'h10);
    tx.send(9'h077, 8, 1'b1);
    rchk(REG_PERIPHERAL_IRQ_FLAGS, 8'h00, "clocked mode");
    bus_wr(REG_TRANSMIT_STATUS_CONTROL, 8'h00);
    bus_wr(REG_RECEIVE_STATUS_CONTROL, 8'h10);
    tx.send(9'h077, 8, 1'b1);
    rchk(REG_PERIPHERAL_IRQ_FLAGS, 8'h00, "port off");
    bus_wr(REG_RECEIVE_STATUS_CONTROL, 8'h90);
    // High speed with wide divider: divisor 3 divides by four, still one clock
    bus_wr(REG_TRANSMIT_STATUS_CONTROL, 8'h04);
    bus_wr(REG_BAUD_DIVISOR_LOW, 8'h03);
    tx.send(9'h081, 8, 1'b1);
    rchk(REG_RECEIVE_DATA_PORT, 8'h81, "scaled divisor");
    // Divisor 7 over four gives a tick every second clock, 32 clocks a bit
    bus_wr(REG_BAUD_DIVISOR_LOW, 8'h07);
    tx.bit_clks = 32;
    tx.send(9'h0C3, 8, 1'b1);
    rchk(REG_RECEIVE_DATA_PORT, 8'hC3, "quarter divisor");
    // Neither speed bit: divisor 0 gives a tick every fourth clock, 64 clocks a bit
    bus_wr(REG_TRANSMIT_STATUS_CONTROL, 8'h00);
    bus_wr(REG_BAUD_CONTROL, 8'h00);
    bus_wr(REG_BAUD_DIVISOR_LOW, 8'h00);
    tx.bit_clks = 64;
    tx.send(9'h0E7, 8, 1'b1);
    rchk(REG_RECEIVE_DATA_PORT, 8'hE7, "slow divider");
    $display("test modes done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_basic();
    t_irq();
    t_overrun();
    t_modes();
    complete_run();
  end
endmodule
